// >>> flash_bus_params.svh
// constants for the flash bus operation decoder
// assumes inclusion by bare name from every design file that needs them
`ifndef FLASH_BUS_PARAMS_SVH
`define FLASH_BUS_PARAMS_SVH

`define FB_ADDR_W        20
`define FB_DATA_W        32
`define FB_CTRL_PINS     8
`define FB_PROT_OFFSET   8'h02
`define FB_RESET_CMD     32'h000000f0
`define FB_BANK_SMALL    2'b11
`define FB_BOOT_SECT_W   8
`define FB_BOOT_BOTTOM   8'h00
`define FB_BOOT_TOP      8'hff
`define FB_PPB_BIT       0
`define FB_DYB_BIT       1
`define FB_BURST_LEN_DEF 2'h3

`endif

// >>> flash_bus_pkg.sv
// types shared by the flash bus decoder files
// assumes nothing beyond a SystemVerilog compiler
package flash_bus_pkg;

   typedef enum logic [0:0]
   {
      MODE_ARRAY_READ,
      MODE_COMMAND
   } op_mode_t;

   typedef enum logic [2:0]
   {
      OP_RESET,
      OP_STANDBY,
      OP_READ,
      OP_WRITE,
      OP_DISABLE,
      OP_OTHER
   } bus_op_t;

endpackage

// >>> flash_burst_counter.sv
// linear wrapping burst address counter
// assumes load, advance and clear come from the decoder on the same clock
`include "flash_bus_params.svh"
module flash_burst_counter #(
   parameter int ADDR_W = `FB_ADDR_W
) (
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   input  wire logic              clear_i,
   input  wire logic              load_i,
   input  wire logic              advance_i,
   input  wire logic [ADDR_W-1:0] start_addr_i,
   input  wire logic [1:0]        len_log2_i,
   output logic      [ADDR_W-1:0] addr_o,
   output logic                   active_o
);

   // wrap inside the aligned group of 2**len words
   function automatic logic [ADDR_W-1:0] wrap_next(input logic [ADDR_W-1:0] a,
                                                   input logic [1:0]        l);
      logic [ADDR_W-1:0] mask;
      logic [ADDR_W-1:0] inc;
      mask = (ADDR_W'(1) << l) - ADDR_W'(1);
      inc = a + ADDR_W'(1);
      wrap_next = (a & ~mask) | (inc & mask);
   endfunction

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         active_o <= 1'b0;
         addr_o   <= '0;
      end
      else if (clear_i)
      begin
         active_o <= 1'b0;
      end
      else if (load_i)
      begin
         // a fresh load drops any burst already running
         active_o <= 1'b1;
         addr_o   <= start_addr_i;
      end
      else if (advance_i && active_o)
      begin
         addr_o <= wrap_next(addr_o, len_log2_i);
      end
   end

endmodule

// >>> flash_bus_operation_decode.sv
// bus operation decoder of a dual bank burst flash with 32 data lines
// assumes host pins arrive asynchronously; array, status and protection
// inputs come from logic on clk_i and answer the registered array address
//
// Contract
// - commands are held in internal latches feeding the mode machine, not memory.
// - wrong sequences may leave command mode; the reset command restores array read.
// - select low, output enable high, write enable low, reset high captures a command.
// - select and output enable low, write enable high, reset high drives read data.
// - deselected with reset high means standby, address ignored, data floating.
// - reset low ignores all inputs and floats the data lines.
// - after power-up or reset the mode machine starts in array read.
// - array data keeps coming until a command write changes the latches.
// - protection read at elevated id voltage, offset 02h returns protection word.
// - data line 0 carries persistent bit, data line 1 the dynamic bit.
// - burst start address load with select low, write enable high, data ignored.
// - burst clock with address valid high advances address and drives burst data.
// - select going high ends the burst and floats the data lines.
// - reset low during a burst aborts it at once and floats the data.
// - a new start address during a burst drops the old burst.
// - write protect guards the two outermost sectors of the chosen boot block; code guards one sector, top 8 address bits all ones (top) or all zeros.
// - start address latched on first clock while valid low or its rising edge.
// - burst cut by reset returns to async read and defaults the burst setup.
// - top address bits 11 select the small bank, other values the large one.
`include "flash_bus_params.svh"
module flash_bus_operation_decode #(
   parameter int ADDR_W = `FB_ADDR_W,
   parameter int DATA_W = `FB_DATA_W
) (
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   input  wire logic              chip_select_n_i,
   input  wire logic              output_enable_n_i,
   input  wire logic              write_enable_n_i,
   input  wire logic              hw_reset_n_i,
   input  wire logic              burst_clk_i,
   input  wire logic              address_valid_n_i,
   input  wire logic              write_protect_n_i,
   input  wire logic              elevated_id_voltage_i,
   input  wire logic [ADDR_W-1:0] addr_i,
   input  wire logic [DATA_W-1:0] data_lines_i,
   output logic      [DATA_W-1:0] data_lines_o,
   output logic                   data_lines_oe_o,
   input  wire logic [DATA_W-1:0] array_data_i,
   input  wire logic [DATA_W-1:0] status_data_i,
   input  wire logic              persistent_protect_bit_i,
   input  wire logic              dynamic_protect_bit_i,
   input  wire logic              burst_enable_i,
   input  wire logic              boot_top_i,
   input  wire logic [1:0]        burst_len_i,
   output logic      [ADDR_W-1:0] array_addr_o,
   output logic                   bank_small_o,
   output logic                   cmd_valid_o,
   output logic      [ADDR_W-1:0] cmd_addr_o,
   output logic      [DATA_W-1:0] cmd_data_o,
   output logic                   cmd_write_protected_o,
   output logic                   array_read_mode_o,
   output logic                   burst_active_o,
   output logic                   config_default_o
);

   localparam int PIN_W = `FB_CTRL_PINS + ADDR_W + DATA_W;

   // ************************************************************
   // pin synchronisers
   // ************************************************************
   logic [PIN_W-1:0] pin_raw;
   logic [PIN_W-1:0] pin_meta;
   logic [PIN_W-1:0] pin_s;
   logic             bclk_d;
   logic             adv_n_d;
   logic             reset_n_d;

   assign pin_raw = {chip_select_n_i, output_enable_n_i, write_enable_n_i, hw_reset_n_i,
                     burst_clk_i, address_valid_n_i, write_protect_n_i,
                     elevated_id_voltage_i, addr_i, data_lines_i};

   // sync flops reset to zero, which reads as hardware reset held low
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         pin_meta <= '0;
         pin_s    <= '0;
      end
      else
      begin
         pin_meta <= pin_raw;
         pin_s    <= pin_meta;
      end
   end

   wire              cs_n_s    = pin_s[PIN_W-1];
   wire              oe_n_s    = pin_s[PIN_W-2];
   wire              we_n_s    = pin_s[PIN_W-3];
   wire              reset_n_s = pin_s[PIN_W-4];
   wire              bclk_s    = pin_s[PIN_W-5];
   wire              adv_n_s   = pin_s[PIN_W-6];
   wire              wp_n_s    = pin_s[PIN_W-7];
   wire              vid_s     = pin_s[PIN_W-8];
   wire [ADDR_W-1:0] addr_s    = pin_s[DATA_W +: ADDR_W];
   wire [DATA_W-1:0] din_s     = pin_s[DATA_W-1:0];

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         bclk_d    <= 1'b0;
         adv_n_d   <= 1'b1;
         reset_n_d <= 1'b0;
      end
      else
      begin
         bclk_d    <= bclk_s;
         adv_n_d   <= adv_n_s;
         reset_n_d <= reset_n_s;
      end
   end

   // ************************************************************
   // bus operation decode
   // ************************************************************
   wire bclk_rise = bclk_s & ~bclk_d;
   wire adv_rise  = adv_n_s & ~adv_n_d;
   wire adv_fall  = ~adv_n_s & adv_n_d;

   wire in_reset  = ~reset_n_s;
   wire standby   = reset_n_s & cs_n_s;
   wire read_op   = reset_n_s & ~cs_n_s & ~oe_n_s & we_n_s;
   wire write_op  = reset_n_s & ~cs_n_s & oe_n_s & ~we_n_s;
   wire nop_op    = reset_n_s & ~cs_n_s & oe_n_s & we_n_s;

   flash_bus_pkg::bus_op_t bus_op;
   assign bus_op = in_reset ? flash_bus_pkg::OP_RESET :
                   standby  ? flash_bus_pkg::OP_STANDBY :
                   read_op  ? flash_bus_pkg::OP_READ :
                   write_op ? flash_bus_pkg::OP_WRITE :
                   nop_op   ? flash_bus_pkg::OP_DISABLE : flash_bus_pkg::OP_OTHER;

   wire prot_sel = vid_s & (addr_s[7:0] == `FB_PROT_OFFSET);

   function automatic logic is_small_bank(input logic [ADDR_W-1:0] a);
      is_small_bank = (a[ADDR_W-1 -: 2] == `FB_BANK_SMALL);
   endfunction

   function automatic logic is_boot_guarded(input logic [ADDR_W-1:0] a, input logic top);
      logic [`FB_BOOT_SECT_W-1:0] sect;
      sect = a[ADDR_W-1 -: `FB_BOOT_SECT_W];
      is_boot_guarded = top ? (sect == `FB_BOOT_TOP) : (sect == `FB_BOOT_BOTTOM);
   endfunction

   // ************************************************************
   // command latches and mode machine
   // ************************************************************
   // capture on write enable release: address and data are stable there,
   // a write cut short by reset is dropped
   logic              write_d;
   logic [ADDR_W-1:0] wr_addr;
   logic [DATA_W-1:0] wr_data;
   wire               end_write = write_d & ~write_op & reset_n_s & we_n_s;
   wire               reset_cmd = (wr_data == `FB_RESET_CMD);

   flash_bus_pkg::op_mode_t mode;
   flash_bus_pkg::op_mode_t next_mode;

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         write_d <= 1'b0;
         wr_addr <= '0;
         wr_data <= '0;
      end
      else
      begin
         write_d <= write_op;
         if (write_op)
         begin
            wr_addr <= addr_s;
            wr_data <= din_s;
         end
      end
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         cmd_valid_o           <= 1'b0;
         cmd_addr_o            <= '0;
         cmd_data_o            <= '0;
         cmd_write_protected_o <= 1'b0;
      end
      else
      begin
         cmd_valid_o <= end_write;
         if (end_write)
         begin
            cmd_addr_o            <= wr_addr;
            cmd_data_o            <= wr_data;
            cmd_write_protected_o <= ~wp_n_s & is_boot_guarded(wr_addr, boot_top_i);
         end
      end
   end

   always_comb
   begin
      next_mode = mode;
      case (mode)
         flash_bus_pkg::MODE_ARRAY_READ:
         begin
            // leave array read only on a command
            if (end_write && !reset_cmd)
            begin
               next_mode = flash_bus_pkg::MODE_COMMAND;
            end
         end
         flash_bus_pkg::MODE_COMMAND:
         begin
            if (end_write && reset_cmd)
            begin
               next_mode = flash_bus_pkg::MODE_ARRAY_READ;
            end
         end
         default:
         begin
            next_mode = flash_bus_pkg::MODE_ARRAY_READ;
         end
      endcase
      if (in_reset)
      begin
         next_mode = flash_bus_pkg::MODE_ARRAY_READ;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         mode <= flash_bus_pkg::MODE_ARRAY_READ;
      end
      else
      begin
         mode <= next_mode;
      end
   end

   // ************************************************************
   // burst control
   // ************************************************************
   logic              loaded_this;
   logic [ADDR_W-1:0] burst_addr;
   logic              burst_run;

   wire burst_ok   = burst_enable_i & reset_n_s & ~cs_n_s & we_n_s &
                     (mode == flash_bus_pkg::MODE_ARRAY_READ);
   // first clock while valid low, or valid rising
   wire load_clk   = bclk_rise & ~adv_n_s;
   wire burst_load = burst_ok & ~loaded_this & (load_clk | adv_rise);
   // advance on clock with valid high
   wire burst_adv  = bclk_rise & read_op & adv_n_s & ~adv_rise;
   wire burst_kill = cs_n_s | in_reset;

   // one load per valid-low period; a new period re-arms
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         loaded_this <= 1'b0;
      end
      else if (burst_load)
      begin
         loaded_this <= 1'b1;
      end
      else if (adv_fall || burst_kill)
      begin
         loaded_this <= 1'b0;
      end
   end

   // start address loads, replacing any running burst
   flash_burst_counter #(
      .ADDR_W(ADDR_W)
   ) u_counter (
      .clk_i       (clk_i),
      .rst_i       (rst_i),
      .clear_i     (burst_kill),
      .load_i      (burst_load),
      .advance_i   (burst_adv),
      .start_addr_i(addr_s),
      .len_log2_i  (burst_len_i),
      .addr_o      (burst_addr),
      .active_o    (burst_run)
   );

   // ************************************************************
   // data lines and status outputs
   // ************************************************************
   wire [ADDR_W-1:0] next_array_addr = burst_run ? burst_addr : addr_s;
   wire [DATA_W-1:0] prot_word;
   assign prot_word = DATA_W'({dynamic_protect_bit_i, persistent_protect_bit_i});

   wire [DATA_W-1:0] next_data = prot_sel ? prot_word :
                                 (mode == flash_bus_pkg::MODE_COMMAND) ? status_data_i :
                                 array_data_i;
   wire next_oe = (bus_op == flash_bus_pkg::OP_READ);

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         data_lines_o      <= '0;
         data_lines_oe_o   <= 1'b0;
         array_addr_o      <= '0;
         bank_small_o      <= 1'b0;
         array_read_mode_o <= 1'b1;
         burst_active_o    <= 1'b0;
         config_default_o  <= 1'b0;
      end
      else
      begin
         data_lines_o      <= next_oe ? next_data : '0;
         data_lines_oe_o   <= next_oe;
         array_addr_o      <= next_array_addr;
         bank_small_o      <= is_small_bank(next_array_addr);
         array_read_mode_o <= (next_mode == flash_bus_pkg::MODE_ARRAY_READ);
         burst_active_o    <= burst_run & ~burst_kill;
         // reset entry defaults the burst setup
         config_default_o  <= reset_n_d & ~reset_n_s;
      end
   end

   // ************************************************************
   // checks
   // ************************************************************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_burst_running;
      burst_run && !burst_kill;
   endsequence

   sequence s_reset_hit;
      !reset_n_s;
   endsequence

   property p_reset_float;
      s_reset_hit |=> !data_lines_oe_o && array_read_mode_o;
   endproperty
   a_reset_float: assert property (p_reset_float) else $error("data driven in reset");

   property p_standby_float;
      standby |=> !data_lines_oe_o;
   endproperty
   a_standby_float: assert property (p_standby_float) else $error("data driven in standby");

   property p_nop_float;
      nop_op |=> !data_lines_oe_o;
   endproperty
   a_nop_float: assert property (p_nop_float) else $error("data driven in no-op");

   property p_read_drive;
      read_op && !prot_sel |=> data_lines_oe_o && (data_lines_o == $past(next_data));
   endproperty
   a_read_drive: assert property (p_read_drive) else $error("read data missing");

   property p_prot_word;
      read_op && prot_sel |=> data_lines_o[`FB_PPB_BIT] == $past(persistent_protect_bit_i)
         && data_lines_o[`FB_DYB_BIT] == $past(dynamic_protect_bit_i)
         && data_lines_o[DATA_W-1:2] == '0;
   endproperty
   a_prot_word: assert property (p_prot_word) else $error("bad protection word");

   property p_cmd_capture;
      end_write |=> cmd_valid_o && cmd_addr_o == $past(wr_addr) ##1 !cmd_valid_o;
   endproperty
   a_cmd_capture: assert property (p_cmd_capture) else $error("command not latched");

   property p_cmd_mode;
      end_write && !reset_cmd && reset_n_s |=> !array_read_mode_o;
   endproperty
   a_cmd_mode: assert property (p_cmd_mode) else $error("array mode kept after command");

   property p_burst_load;
      burst_load |=> burst_run ##0 burst_addr == $past(addr_s);
   endproperty
   a_burst_load: assert property (p_burst_load) else $error("burst start not latched");

   property p_burst_end;
      s_burst_running ##1 cs_n_s |=> !burst_run ##1 !burst_active_o && !data_lines_oe_o;
   endproperty
   a_burst_end: assert property (p_burst_end) else $error("burst survived deselect");

   property p_burst_abort;
      s_burst_running ##1 s_reset_hit |=> !burst_run && !data_lines_oe_o && config_default_o;
   endproperty
   a_burst_abort: assert property (p_burst_abort) else $error("burst survived reset");

   property p_burst_step;
      burst_adv && burst_run && !burst_kill && burst_len_i != 2'h0 |=>
         burst_addr != $past(burst_addr);
   endproperty
   a_burst_step: assert property (p_burst_step) else $error("burst did not advance");

   property p_guard;
      end_write && !wp_n_s && is_boot_guarded(wr_addr, boot_top_i) |=> cmd_write_protected_o;
   endproperty
   a_guard: assert property (p_guard) else $error("guarded sector not flagged");

   property p_bank;
      ##1 bank_small_o == (array_addr_o[ADDR_W-1 -: 2] == `FB_BANK_SMALL);
   endproperty
   a_bank: assert property (p_bank) else $error("bank select wrong");

endmodule

// >>> flash_host_model.sv
// host side bus model that drives select, enables, reset, burst clock, valid, address and data pins; write protect and id voltage come from the bench
// assumes its tasks are called just after a rising clk_i edge
module flash_host_model (
   input  wire logic        clk_i,
   output logic             cs_n_o,
   output logic             oe_n_o,
   output logic             we_n_o,
   output logic             hw_reset_n_o,
   output logic             bclk_o,
   output logic             adv_n_o,
   output logic [19:0]      addr_o,
   output logic [31:0]      data_o
);
   timeunit 1ns;
   timeprecision 100ps;

   initial
   begin
      {cs_n_o, oe_n_o, we_n_o, hw_reset_n_o, adv_n_o} = 5'h1f;
      bclk_o = 1'b0;
      addr_o = 20'h00000;
      data_o = 32'h00000000;
   end

   task automatic wait_edges(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask

   task automatic set_bus(input logic cs_n, oe_n, adv_n, input logic [19:0] a);
      addr_o = a;
      we_n_o = 1'b1;
      cs_n_o = cs_n;
      oe_n_o = oe_n;
      adv_n_o = adv_n;
   endtask

   task automatic write_cmd(input logic [19:0] a, input logic [31:0] d);
      addr_o = a;
      data_o = d;
      oe_n_o = 1'b1;
      cs_n_o = 1'b0;
      we_n_o = 1'b0;
      wait_edges(5);
      we_n_o = 1'b1;
      wait_edges(1);
      cs_n_o = 1'b1;
      // a released bus shows the inverse, never a stale copy
      data_o = ~d;
   endtask

   task automatic burst_tick();
      bclk_o = 1'b1;
      wait_edges(4);
      bclk_o = 1'b0;
      wait_edges(4);
   endtask

   task automatic set_reset(input logic v);
      hw_reset_n_o = v;
   endtask
endmodule

// >>> testbench.sv
// self-checking bench for the flash bus operation decoder
// assumes the design files and flash_host_model are compiled before it
`include "flash_bus_params.svh"
module testbench;
   timeunit 1ns;
   timeprecision 100ps;

   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        chip_select_n_i, output_enable_n_i, write_enable_n_i, hw_reset_n_i;
   logic        burst_clk_i, address_valid_n_i;
   logic        write_protect_n_i, elevated_id_voltage_i, boot_top_i, burst_enable_i;
   logic        persistent_protect_bit_i, dynamic_protect_bit_i;
   logic [1:0]  burst_len_i;
   logic [19:0] addr_i, array_addr_o, cmd_addr_o;
   logic [31:0] host_data, data_lines_i, data_lines_o, array_data_i, cmd_data_o;
   logic        data_lines_oe_o, bank_small_o, cmd_valid_o, cmd_write_protected_o;
   logic        array_read_mode_o, burst_active_o, config_default_o;
   int          miscompares = 0;
   int          checked = 0;
   // status words are arbitrary, only distinct from any array word
   logic [31:0] status_data_i;

   function automatic logic [31:0] word_of(input logic [19:0] a);
      return {12'h5a0, a};
   endfunction

   assign array_data_i = word_of(array_addr_o);
   assign data_lines_i = data_lines_oe_o ? data_lines_o : host_data;

   initial
   begin
      forever #12.5 clk_i = ~clk_i;
   end

   flash_host_model host (.clk_i, .cs_n_o(chip_select_n_i), .oe_n_o(output_enable_n_i),
      .we_n_o(write_enable_n_i), .hw_reset_n_o(hw_reset_n_i), .bclk_o(burst_clk_i),
      .adv_n_o(address_valid_n_i), .addr_o(addr_i), .data_o(host_data));

   flash_bus_operation_decode dut (.clk_i, .rst_i, .chip_select_n_i, .output_enable_n_i,
      .write_enable_n_i, .hw_reset_n_i, .burst_clk_i, .address_valid_n_i,
      .write_protect_n_i, .elevated_id_voltage_i, .addr_i, .data_lines_i, .data_lines_o,
      .data_lines_oe_o, .array_data_i, .status_data_i,
      .persistent_protect_bit_i, .dynamic_protect_bit_i, .burst_enable_i, .boot_top_i,
      .burst_len_i, .array_addr_o, .bank_small_o, .cmd_valid_o, .cmd_addr_o, .cmd_data_o,
      .cmd_write_protected_o, .array_read_mode_o, .burst_active_o, .config_default_o);

   task automatic compare_word(input logic [31:0] got, exp);
      checked++;
      if (got !== exp)
      begin
         miscompares++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic compare_flag(input logic got, exp);
      compare_word({31'h0, got}, {31'h0, exp});
   endtask

   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic read_check(input logic [19:0] a, input logic [31:0] exp);
      host.set_bus(1'b0, 1'b0, 1'b1, a);
      host.wait_edges(4);
      compare_flag(data_lines_oe_o, 1'b1);
      compare_word(data_lines_o, exp);
      compare_flag(bank_small_o, &a[19:18]);
      host.set_bus(1'b1, 1'b1, 1'b1, a);
      host.wait_edges(4);
      compare_flag(data_lines_oe_o, 1'b0);
   endtask

   task automatic cmd_check(input logic [19:0] a, input logic [31:0] d, input logic prot);
      host.write_cmd(a, d);
      host.wait_edges(2);
      compare_flag(cmd_valid_o, 1'b1);
      compare_word({12'h0, cmd_addr_o}, {12'h0, a});
      compare_word(cmd_data_o, d);
      compare_flag(cmd_write_protected_o, prot);
      compare_flag(array_read_mode_o, d === `FB_RESET_CMD);
      host.wait_edges(1);
      compare_flag(cmd_valid_o, 1'b0);
   endtask

   task automatic test_reads_and_idle();
      compare_flag(array_read_mode_o, 1'b1);
      read_check(20'hc1234, word_of(20'hc1234));
      read_check(20'h81234, word_of(20'h81234));
      host.set_bus(1'b0, 1'b1, 1'b1, 20'h00010);
      host.wait_edges(4);
      compare_flag(data_lines_oe_o, 1'b0);
      host.set_bus(1'b1, 1'b0, 1'b1, 20'h00020);
      host.wait_edges(4);
      compare_flag(data_lines_oe_o, 1'b0);
      compare_word(data_lines_o, 32'h00000000);
      $display("test reads and idle done");
   endtask

   task automatic test_commands();
      write_protect_n_i = 1'b0;
      cmd_check(20'h00555, 32'h000000aa, 1'b1);
      read_check(20'h12345, status_data_i);
      cmd_check(20'hff555, `FB_RESET_CMD, 1'b0);
      read_check(20'h12345, word_of(20'h12345));
      boot_top_i = 1'b1;
      cmd_check(20'hff000, `FB_RESET_CMD, 1'b1);
      write_protect_n_i = 1'b1;
      cmd_check(20'hff000, `FB_RESET_CMD, 1'b0);
      boot_top_i = 1'b0;
      $display("test commands done");
   endtask

   task automatic test_protection();
      elevated_id_voltage_i = 1'b1;
      for (int i = 0; i < 4; i++)
      begin
         {dynamic_protect_bit_i, persistent_protect_bit_i} = i[1:0];
         read_check(20'h4c002, {30'h0, i[1:0]});
      end
      elevated_id_voltage_i = 1'b0;
      $display("test protection done");
   endtask

   task automatic test_hw_reset();
      cmd_check(20'h00aaa, 32'h00000055, 1'b0);
      status_data_i = 32'h00000044;
      host.set_bus(1'b0, 1'b0, 1'b1, 20'h00100);
      host.wait_edges(4);
      compare_word(data_lines_o, status_data_i);
      host.set_reset(1'b0);
      host.wait_edges(3);
      compare_flag(config_default_o, 1'b1);
      compare_flag(data_lines_oe_o, 1'b0);
      compare_flag(array_read_mode_o, 1'b1);
      host.wait_edges(1);
      compare_flag(config_default_o, 1'b0);
      host.set_reset(1'b1);
      host.set_bus(1'b1, 1'b1, 1'b1, 20'h00000);
      host.wait_edges(4);
      $display("test hardware reset done");
   endtask

   task automatic load_burst(input logic [19:0] a);
      host.set_bus(1'b0, 1'b1, 1'b0, a);
      host.wait_edges(4);
      host.set_bus(1'b0, 1'b1, 1'b1, a);
      host.wait_edges(6);
   endtask

   task automatic test_burst(input logic by_reset, input logic [1:0] len);
      burst_enable_i = 1'b1;
      burst_len_i = len;
      load_burst(20'h40001);
      compare_flag(burst_active_o, 1'b1);
      compare_word({12'h0, array_addr_o}, 32'h00040001);
      host.set_bus(1'b0, 1'b0, 1'b1, 20'h00000);
      host.wait_edges(4);
      compare_word(data_lines_o, word_of(20'h40001));
      for (int i = 2; i < 6; i++)
      begin
         host.burst_tick();
         compare_word(data_lines_o, word_of(20'h40000 | (i[2:0] & {len[0], 2'h3})));
      end
      load_burst(20'h40006);
      host.set_bus(1'b0, 1'b0, 1'b1, 20'h00000);
      host.burst_tick();
      compare_word(data_lines_o, word_of(20'h40007));
      if (by_reset)
         host.set_reset(1'b0);
      else
         host.set_bus(1'b1, 1'b0, 1'b1, 20'h00000);
      host.wait_edges(4);
      compare_flag(burst_active_o, 1'b0);
      compare_flag(data_lines_oe_o, 1'b0);
      compare_flag(array_read_mode_o, 1'b1);
      host.set_reset(1'b1);
      host.set_bus(1'b1, 1'b1, 1'b1, 20'h00000);
      host.wait_edges(4);
      burst_enable_i = 1'b0;
      $display("test burst done");
   endtask

   // the whole sequence needs well under two thousand clocks
   initial
   begin
      #500000;
      miscompares++;
      $display("watchdog expired at %0t", $time);
      report_and_stop();
   end

   initial
   begin
      {write_protect_n_i, elevated_id_voltage_i, boot_top_i, burst_enable_i} = 4'h8;
      {persistent_protect_bit_i, dynamic_protect_bit_i} = 2'h0;
      burst_len_i = 2'h2;
      status_data_i = 32'h00000080;
      repeat (20) @(posedge clk_i);
      #1;
      rst_i = 1'b0;
      host.wait_edges(4);
      test_reads_and_idle();
      test_commands();
      test_protection();
      test_hw_reset();
      test_burst(1'b0, 2'h2);
      test_burst(1'b1, 2'h3);
      report_and_stop();
   end
endmodule
